// [chan_exec.sv]
`timescale 1ns/1ns
// Operation
// - Count-down subtracts one, writes result back.
// - Count-down sets carry, sign, zero flags.
// - Extended count-down addresses entry concatenated with index.
// - Extended count-down illegal unless config bit four.
// - Dequeue loads from head, advances head.
// - Enqueue stores at tail, advances tail.
// - Queues sixteen items, aligned, growing upward.
// - Adapter read for registers 0,1,5,6,7.
// - Adapter write for registers 2,3,4.
// - Give-back posts complete, range, control bits.
// - Give-back interrupts host when control bit 8.
// - Give-back acts only in extended mode.
// - Give-back zero flag shows no prior next-block.
// - Next-block copies status entries, restores range.
// - Compatibility next-block posts complete, interrupts when control bit 8.
// - Next-block fetches block, sets valid, last flags.
// - Status input loads ready, overrun, underrun byte.
// - Pointer init writes counter plus displacement.
// - Line input reads line register 0,1,5.
// - HDLC line input 7 pops data and status.
module chan_exec (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic INSTR_VALID,
  input wire logic [7:0] INSTR_OP,
  input wire logic [7:0] INSTR_ARG,
  input wire logic [15:0] INSTR_DISP,
  input wire logic [15:0] PC,
  input wire logic [7:0] CONFIG_A,
  input wire logic [7:0] ADAPTER_RDATA,
  input wire logic [7:0] ADAPTER_STATUS,
  input wire logic [7:0] HDLC_STATUS,
  input wire logic [15:0] CCB_CTL,
  input wire logic [15:0] CCB_RESID,
  input wire logic [15:0] CCB_INIT_RANGE,
  input wire logic [15:0] NEXT_CCB_CTL,
  output logic INSTR_DONE,
  output logic ILLEGAL,
  output logic [2:0] ADAPTER_SEL,
  output logic ADAPTER_RD,
  output logic ADAPTER_WR,
  output logic ADAPTER_POP,
  output logic [7:0] ADAPTER_WDATA,
  output logic POST_STB,
  output logic POST_COMPLETE,
  output logic [15:0] POST_STATUS,
  output logic [15:0] POST_RANGE,
  output logic [4:0] POST_CTL_HI,
  output logic FETCH_STB,
  output logic HOST_IRQ,
  output logic [7:0] R_REG,
  output logic [7:0] B_REG,
  output logic FLAG_C,
  output logic FLAG_SB,
  output logic FLAG_Z,
  output logic FLAG_V,
  output logic FLAG_LB,
  output logic FLAG_LC
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] r;          // Working register.
    logic [7:0] b;          // Index register.
    logic c, sb, z, v, lb, lc;
    logic gnb_seen;         // A next-block ran since the last extended-mode give-back.
    logic done, illegal, rd, wr, pop, post, complete, fetch, irq;
    logic [2:0] sel;
    logic [7:0] wdata;
    logic [15:0] pstat, prange;
    logic [4:0] pctl;
  } st_t;
  st_t s, next_s;
  // Line table entries; 64 for the channel pair.
  logic [7:0] lct [0:63];
  // Local store reached by the extended count-down, 16-bit address.
  logic [7:0] lstore [0:65535];
  logic [5:0] lct_wa;
  logic [7:0] lct_wd;
  logic lct_we, lct_we2;
  logic [5:0] lct_wa2;
  logic [7:0] lct_wd2;
  logic ls_we;
  logic [15:0] ls_addr;
  logic [7:0] ls_wd;
  logic [7:0] dec_val;
  logic dec_c;
  logic [7:0] flag_src;
  logic f_sign, f_zero;
  logic [7:0] head, tail;
  logic [15:0] ilp_val;

  chan_flags u_flags (
    .value(flag_src),
    .sign(f_sign),
    .zero(f_zero)
  );

  // ************************************************************
  // Decode and execute
  // ************************************************************
  // One instruction per accepted cycle; all effects land on the next edge.
  always_comb begin
    logic [8:0] diff;
    logic [7:0] operand;
    diff = 9'h000;
    operand = 8'h00;
    next_s = s;
    next_s.done = 1'b0;
    next_s.illegal = 1'b0;
    next_s.rd = 1'b0;
    next_s.wr = 1'b0;
    next_s.pop = 1'b0;
    next_s.post = 1'b0;
    next_s.complete = 1'b0;
    next_s.fetch = 1'b0;
    next_s.irq = 1'b0;
    lct_we = 1'b0;
    lct_wa = INSTR_ARG[5:0];
    lct_wd = 8'h00;
    lct_we2 = 1'b0;
    lct_wa2 = INSTR_ARG[5:0];
    lct_wd2 = 8'h00;
    ls_we = 1'b0;
    ls_addr = {lct[INSTR_ARG[5:0]], s.b};
    ls_wd = 8'h00;
    flag_src = 8'h00;
    // Queue pointers live in the entry named by the argument pair.
    head = lct[INSTR_ARG[5:0]];
    tail = lct[INSTR_ARG[5:0] + 6'h01];
    ilp_val = PC + INSTR_DISP;
    dec_val = 8'h00;
    dec_c = 1'b0;
    if (INSTR_VALID) begin
      next_s.done = 1'b1;
      unique case (INSTR_OP)
        chan_pkg::OP_DEC_R, chan_pkg::OP_DEC_L, chan_pkg::OP_DEC_N,
        chan_pkg::OP_DEC_B, chan_pkg::OP_DEC_X: begin
          // Operand selection per addressing form.
          if (INSTR_OP == chan_pkg::OP_DEC_R) operand = s.r;
          else if (INSTR_OP == chan_pkg::OP_DEC_L) operand = lct[INSTR_ARG[5:0]];
          else if (INSTR_OP == chan_pkg::OP_DEC_N) operand = lct[s.b[5:0]];
          else if (INSTR_OP == chan_pkg::OP_DEC_B) operand = s.b;
          else operand = lstore[ls_addr];
          // Borrow shows as a carry out of the nine-bit difference.
          diff = {1'b0, operand} - {1'b0, chan_pkg::ONE8};
          dec_val = diff[7:0];
          dec_c = diff[8];
          if (INSTR_OP == chan_pkg::OP_DEC_X &&
              !CONFIG_A[chan_pkg::CFG_XLS_BIT]) begin
            next_s.illegal = 1'b1;
            // A refused form completes nothing, exactly like an unknown opcode.
            next_s.done = 1'b0;
          end else begin
            flag_src = dec_val;
            next_s.c = dec_c;
            next_s.sb = f_sign;
            next_s.z = f_zero;
            if (INSTR_OP == chan_pkg::OP_DEC_R) next_s.r = dec_val;
            else if (INSTR_OP == chan_pkg::OP_DEC_B) next_s.b = dec_val;
            else if (INSTR_OP == chan_pkg::OP_DEC_L) begin
              lct_we = 1'b1;
              lct_wd = dec_val;
            end else if (INSTR_OP == chan_pkg::OP_DEC_N) begin
              lct_we = 1'b1;
              lct_wa = s.b[5:0];
              lct_wd = dec_val;
            end else begin
              ls_we = 1'b1;
              ls_wd = dec_val;
            end
          end
        end
        chan_pkg::OP_DEQ: begin
          // Head wraps inside its aligned sixteen-entry block.
          flag_src = lct[head[5:0]];
          next_s.r = flag_src;
          next_s.sb = f_sign;
          next_s.z = f_zero;
          lct_we = 1'b1;
          lct_wd = (head & chan_pkg::QUEUE_MASK) |
                   ((head + chan_pkg::ONE8) & ~chan_pkg::QUEUE_MASK);
        end
        chan_pkg::OP_ENQ: begin
          flag_src = s.r;
          next_s.sb = f_sign;
          next_s.z = f_zero;
          lct_we = 1'b1;
          lct_wa = tail[5:0];
          lct_wd = s.r;
          lct_we2 = 1'b1;
          lct_wa2 = INSTR_ARG[5:0] + 6'h01;
          lct_wd2 = (tail & chan_pkg::QUEUE_MASK) |
                    ((tail + chan_pkg::ONE8) & ~chan_pkg::QUEUE_MASK);
        end
        chan_pkg::OP_FIN, chan_pkg::OP_IN: begin
          next_s.sel = INSTR_ARG[2:0];
          next_s.rd = 1'b1;
          if (INSTR_OP == chan_pkg::OP_IN && INSTR_ARG[2:0] == chan_pkg::LR_HDLC) begin
            // Two characters leave the receive FIFO in one go.
            next_s.pop = 1'b1;
            next_s.r = ADAPTER_RDATA;
            flag_src = HDLC_STATUS;
            lct_we = 1'b1;
            lct_wa = chan_pkg::LCT_HDLC_STAT;
            lct_wd = HDLC_STATUS;
          end else begin
            next_s.r = ADAPTER_RDATA;
            flag_src = ADAPTER_RDATA;
          end
          next_s.sb = f_sign;
          next_s.z = f_zero;
        end
        chan_pkg::OP_ADAPTER_REG_WRITE: begin
          next_s.sel = INSTR_ARG[2:0];
          next_s.wr = 1'b1;
          next_s.wdata = s.r;
        end
        chan_pkg::OP_IAS: begin
          // Reserved nibble and bit 5 are forced to zero.
          flag_src = ADAPTER_STATUS & (chan_pkg::STAT_READY |
                     chan_pkg::STAT_OVR | chan_pkg::STAT_UND);
          next_s.r = flag_src;
          next_s.sb = f_sign;
          next_s.z = f_zero;
        end
        chan_pkg::OP_ILP: begin
          lct_we = 1'b1;
          lct_wd = ilp_val[15:8];
          lct_we2 = 1'b1;
          lct_wa2 = INSTR_ARG[5:0] + 6'h01;
          lct_wd2 = ilp_val[7:0];
        end
        chan_pkg::OP_GNB: begin
          next_s.post = 1'b1;
          // Channel half picks receive or transmit status pair.
          next_s.pstat = INSTR_ARG[5] ?
            {lct[chan_pkg::LCT_TX_STAT0], lct[chan_pkg::LCT_TX_STAT1]} :
            {lct[chan_pkg::LCT_RX_STAT0], lct[chan_pkg::LCT_RX_STAT1]};
          next_s.prange = CCB_INIT_RANGE;
          next_s.pctl = CCB_CTL[15:11];
          if (!CONFIG_A[chan_pkg::CFG_EXT_BIT]) begin
            next_s.complete = 1'b1;
            next_s.irq = CCB_CTL[chan_pkg::CTL_INT_BIT];
          end
          next_s.fetch = 1'b1;
          next_s.v = NEXT_CCB_CTL[chan_pkg::CTL_VALID_BIT];
          next_s.lb = NEXT_CCB_CTL[chan_pkg::CTL_LAST_BIT];
          next_s.lc = 1'b0;
          next_s.gnb_seen = 1'b1;
        end
        chan_pkg::OP_GIVE: begin
          if (CONFIG_A[chan_pkg::CFG_EXT_BIT]) begin
            next_s.post = 1'b1;
            next_s.complete = 1'b1;
            next_s.pstat = s.pstat;
            next_s.prange = CCB_RESID;
            next_s.pctl = lct[s.b[5:0]][4:0];
            next_s.irq = CCB_CTL[chan_pkg::CTL_INT_BIT];
            next_s.z = !s.gnb_seen;
            next_s.gnb_seen = 1'b0;
          end
        end
        default: begin
          next_s.done = 1'b0;
          next_s.illegal = 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // The control struct resets; the table and store are plain memory.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Memory writes; no reset so they map onto RAM.
  always_ff @(posedge SYS_CLK) begin
    if (lct_we) lct[lct_wa] <= lct_wd;
    if (lct_we2) lct[lct_wa2] <= lct_wd2;
    if (ls_we) lstore[ls_addr] <= ls_wd;
  end

  always_comb begin
    INSTR_DONE = s.done;
    ILLEGAL = s.illegal;
    ADAPTER_SEL = s.sel;
    ADAPTER_RD = s.rd;
    ADAPTER_WR = s.wr;
    ADAPTER_POP = s.pop;
    ADAPTER_WDATA = s.wdata;
    POST_STB = s.post;
    POST_COMPLETE = s.complete;
    POST_STATUS = s.pstat;
    POST_RANGE = s.prange;
    POST_CTL_HI = s.pctl;
    FETCH_STB = s.fetch;
    HOST_IRQ = s.irq;
    R_REG = s.r;
    B_REG = s.b;
    FLAG_C = s.c;
    FLAG_SB = s.sb;
    FLAG_Z = s.z;
    FLAG_V = s.v;
    FLAG_LB = s.lb;
    FLAG_LC = s.lc;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_dec_illegal: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_DEC_X && !CONFIG_A[chan_pkg::CFG_XLS_BIT]
    |=> ILLEGAL && !INSTR_DONE)
    else $error("extended count-down not refused");
  a_decr_value: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_DEC_R |=> R_REG == $past(R_REG) - 8'h01)
    else $error("count-down result wrong");
  a_decr_zero: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_DEC_R |=> FLAG_Z == (R_REG == 8'h00))
    else $error("zero flag wrong");
  a_give_nop: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_GIVE && !CONFIG_A[chan_pkg::CFG_EXT_BIT]
    |=> !POST_STB)
    else $error("give-back acted outside extended mode");
  a_gnb_ext: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_GNB && CONFIG_A[chan_pkg::CFG_EXT_BIT]
    |=> !HOST_IRQ && !POST_COMPLETE)
    else $error("extended next-block posted");
  a_gnb_lc: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_GNB |=> FETCH_STB && !FLAG_LC)
    else $error("next-block fetch missing");
  a_adapter_reg_write_flags: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_ADAPTER_REG_WRITE |=> $stable(FLAG_Z) && ADAPTER_WR)
    else $error("adapter write disturbed flags");
  // Only ready, overrun and underrun may show; bit four is ready, not reserved.
  a_ias_mask: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    INSTR_VALID && INSTR_OP == chan_pkg::OP_IAS
    |=> (R_REG & ~(chan_pkg::STAT_READY | chan_pkg::STAT_OVR | chan_pkg::STAT_UND)) == 8'h00)
    else $error("status byte reserved bits set");
  c_give: cover property (@(posedge SYS_CLK) POST_STB && POST_COMPLETE);
  c_irq: cover property (@(posedge SYS_CLK) HOST_IRQ);
  c_illegal: cover property (@(posedge SYS_CLK) ILLEGAL);
endmodule // chan_exec

// [chan_pkg.sv]
package chan_pkg;
  // ************************************************************
  // Opcodes (first instruction byte)
  // ************************************************************
  localparam logic [7:0] OP_DEC_R = 8'h9E;
  localparam logic [7:0] OP_DEC_L = 8'h5E;
  localparam logic [7:0] OP_DEC_N = 8'h8E;
  localparam logic [7:0] OP_DEC_B = 8'hBE;
  localparam logic [7:0] OP_DEC_X = 8'hCE;
  localparam logic [7:0] OP_DEQ = 8'hAF;
  localparam logic [7:0] OP_ENQ = 8'hAE;
  localparam logic [7:0] OP_FIN = 8'h28;
  localparam logic [7:0] OP_ADAPTER_REG_WRITE = 8'h38;
  localparam logic [7:0] OP_GIVE = 8'h12;
  localparam logic [7:0] OP_GNB = 8'h20;
  localparam logic [7:0] OP_IAS = 8'h92;
  localparam logic [7:0] OP_ILP = 8'hF9;
  localparam logic [7:0] OP_IN = 8'h21;
  // ************************************************************
  // Line table locations and field positions
  // ************************************************************
  localparam logic [5:0] LCT_RX_STAT0 = 6'h10;
  localparam logic [5:0] LCT_RX_STAT1 = 6'h11;
  localparam logic [5:0] LCT_TX_STAT0 = 6'h30;
  localparam logic [5:0] LCT_TX_STAT1 = 6'h31;
  localparam logic [5:0] LCT_HDLC_STAT = 6'h0B;
  localparam int CFG_EXT_BIT = 0;
  localparam int CFG_XLS_BIT = 4;
  localparam int CTL_INT_BIT = 8;
  localparam int CTL_VALID_BIT = 15;
  localparam int CTL_LAST_BIT = 14;
  localparam logic [7:0] QUEUE_MASK = 8'hF0;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [2:0] LR_HDLC = 3'h7;
  localparam logic [7:0] STAT_READY = 8'h10;
  localparam logic [7:0] STAT_OVR = 8'h40;
  localparam logic [7:0] STAT_UND = 8'h80;
endpackage

// [chan_flags.sv]
`timescale 1ns/1ns
// Computes sign and zero indicators of an eight-bit value.
module chan_flags (
  input wire logic [7:0] value,
  output logic sign,
  output logic zero
);
  // Sign follows the top bit; zero is a wide nor.
  always_comb begin
    sign = value[7];
    zero = (value == 8'h00);
  end
endmodule // chan_flags

// [chan_adapter_model.sv]
`timescale 1ns/1ns
// ************************************************************
// Line adapter model: register file, status byte, receive FIFO
// ************************************************************
module chan_adapter_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] rd_sel,
  input wire logic wr,
  input wire logic [2:0] wr_sel,
  input wire logic [7:0] wdata,
  input wire logic pop,
  output logic [7:0] rdata,
  output logic [7:0] status,
  output logic [7:0] hdlc_stat
);
  // Adapter registers; 2 to 5 all reset to zero, the others hold distinct values so a wrong select among them shows up.
  logic [7:0] regs [8];
  // Receive FIFO position, one data and status pair per pop.
  logic ptr;

  // Registers take writes; the FIFO steps on each pop.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regs <= '{8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7E, 8'h3C};
      ptr <= 1'b0;
    end else begin
      if (wr) begin
        regs[wr_sel] <= wdata;
      end
      if (pop) begin
        ptr <= ~ptr;
      end
    end
  end

  // Read data follows the selected register; register seven is the FIFO data port.
  assign rdata = (rd_sel == 3'h7) ? (ptr ? 8'h55 : 8'h3C) : regs[rd_sel];
  // The status character differs from its data so flag sourcing can be told apart.
  assign hdlc_stat = ptr ? 8'h00 : 8'h81;
  // Bit five is driven high on purpose: the block must still show it as zero.
  assign status = 8'hF0;
endmodule // chan_adapter_model

// [channel_ctrl_instr_subset_tb.sv]
`timescale 1ns/1ns
module channel_ctrl_instr_subset_tb;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [7:0] op = 8'h00, arg = 8'h00, cfg = 8'h00;
  logic [15:0] pc = 16'h0000, dsp = 16'hFF00, ctl = 16'h0100;
  logic [15:0] resid = 16'h0123, irange = 16'h0456, nctl = 16'h0000;
  logic done, ill, ard, awr, apop, pstb, pcomp, fstb, irq, fc, fsb, fz, fv, flb, flc;
  logic [2:0] asel;
  logic [7:0] wd, rr, br, ardata, astat, hstat;
  logic [15:0] pstat, prange;
  logic [4:0] pctl;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  // Values the adapter model holds, mirrored here for expectations.
  localparam logic [7:0] AV [8] = '{8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7E, 8'h3C};

  always #10 clk = ~clk;

  chan_exec chan_exec_inst (.SYS_CLK(clk), .RESETN(rst_n), .INSTR_VALID(vld), .INSTR_OP(op),
    .INSTR_ARG(arg), .INSTR_DISP(dsp), .PC(pc), .CONFIG_A(cfg), .ADAPTER_RDATA(ardata),
    .ADAPTER_STATUS(astat), .HDLC_STATUS(hstat), .CCB_CTL(ctl), .CCB_RESID(resid),
    .CCB_INIT_RANGE(irange), .NEXT_CCB_CTL(nctl), .INSTR_DONE(done), .ILLEGAL(ill),
    .ADAPTER_SEL(asel), .ADAPTER_RD(ard), .ADAPTER_WR(awr), .ADAPTER_POP(apop),
    .ADAPTER_WDATA(wd), .POST_STB(pstb), .POST_COMPLETE(pcomp), .POST_STATUS(pstat),
    .POST_RANGE(prange), .POST_CTL_HI(pctl), .FETCH_STB(fstb), .HOST_IRQ(irq), .R_REG(rr),
    .B_REG(br), .FLAG_C(fc), .FLAG_SB(fsb), .FLAG_Z(fz), .FLAG_V(fv), .FLAG_LB(flb),
    .FLAG_LC(flc));

  chan_adapter_model chan_adapter_model_inst (.clk(clk), .rst_n(rst_n), .rd_sel(arg[2:0]),
    .wr(awr), .wr_sel(asel), .wdata(wd), .pop(apop), .rdata(ardata), .status(astat),
    .hdlc_stat(hstat));

  // ************************************************************
  // Tasks
  // ************************************************************
  // Counts a comparison and reports it at once when it differs.
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask

  // Issues one instruction and returns when its registered answer has settled.
  task automatic run(input logic [7:0] o, input logic [7:0] a);
    @(posedge clk);
    vld <= 1'b1;
    op <= o;
    arg <= a;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask

  // Sets mode and block inputs on an edge, ahead of the next instruction.
  task automatic set_in(input logic [7:0] c, input logic [15:0] p, input logic [15:0] n);
    @(posedge clk);
    cfg <= c;
    pc <= p;
    nctl <= n;
  endtask

  // Writes a pointer pair; the displacement is negative to exercise the signed add.
  task automatic pointer_init_op(input logic [7:0] a, input logic [15:0] v);
    set_in(cfg, v + 16'h0100, nctl);
    run(chan_pkg::OP_ILP, a);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang is cut short well after the sequence should have ended.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test;
    end
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Index count-down from zero wraps and borrows.
    run(chan_pkg::OP_DEC_B, 8'h00);
    chk("b_reg", br, 16'h00FF);
    chk("flags", {fc, fsb, fz}, 3'b110);
    $display("test index_countdown finished");
    // Adapter register and line register reads over every legal number.
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 8; i++) begin
        if (i inside {0, 1, 5} || (k == 0 && i inside {6, 7})) begin
          run(k == 0 ? chan_pkg::OP_FIN : chan_pkg::OP_IN, 8'(i));
          chk("r_reg", rr, AV[i]);
          chk("sb_z", {fsb, fz}, {AV[i][7], AV[i] == 8'h00});
          if (k == 0) begin
            chk("rd_sel", {ard, asel}, {1'b1, 3'(i)});
          end
        end
      end
    end
    $display("test adapter_reads finished");
    // Working register count-down through zero and onto zero.
    run(chan_pkg::OP_DEC_R, 8'h00);
    chk("r_reg", rr, 16'h00FF);
    chk("flags", {fc, fsb, fz}, 3'b110);
    run(chan_pkg::OP_FIN, 8'h00);
    run(chan_pkg::OP_DEC_R, 8'h00);
    chk("r_reg", rr, 16'h0000);
    chk("flags", {fc, fsb, fz}, 3'b001);
    $display("test r_countdown finished");
    // Writes leave the indicators as the previous read set them.
    run(chan_pkg::OP_FIN, 8'h01);
    for (int r = 2; r < 5; r++) begin
      run(chan_pkg::OP_ADAPTER_REG_WRITE, 8'(r));
      chk("write", {awr, asel, wd}, {1'b1, 3'(r), 8'h80});
      chk("sb_z", {fsb, fz}, 2'b10);
    end
    $display("test adapter_writes finished");
    // Status byte shows bit five as zero.
    run(chan_pkg::OP_IAS, 8'h00);
    chk("status", rr, 16'h00D0);
    chk("sb_z", {fsb, fz}, 2'b10);
    // HDLC input pops a pair; indicators follow the status character.
    run(chan_pkg::OP_IN, 8'h07);
    chk("pop", apop, 1'b1);
    chk("r_reg", rr, 16'h003C);
    chk("sb_z", {fsb, fz}, 2'b10);
    pointer_init_op(8'h04, 16'h0B0B);
    run(chan_pkg::OP_DEQ, 8'h04);
    chk("entry11", rr, 16'h0081);
    $display("test status_inputs finished");
    // Queue near the top of its sixteen-entry block wraps both pointers.
    pointer_init_op(8'h02, 16'h2F2F);
    run(chan_pkg::OP_FIN, 8'h01);
    run(chan_pkg::OP_ENQ, 8'h02);
    chk("sb_z", {fsb, fz}, 2'b10);
    run(chan_pkg::OP_FIN, 8'h05);
    run(chan_pkg::OP_ENQ, 8'h02);
    chk("sb_z", {fsb, fz}, 2'b01);
    run(chan_pkg::OP_FIN, 8'h00);
    run(chan_pkg::OP_DEQ, 8'h02);
    chk("deq1", {rr, 6'h00, fsb, fz}, 16'h8002);
    run(chan_pkg::OP_DEQ, 8'h02);
    chk("deq2", {rr, 6'h00, fsb, fz}, 16'h0001);
    $display("test queue_wrap finished");
    // Table entry count-down, read back through the queue head.
    pointer_init_op(8'h08, 16'h0900);
    run(chan_pkg::OP_DEC_L, 8'h09);
    chk("flags", {fc, fsb, fz}, 3'b110);
    run(chan_pkg::OP_DEQ, 8'h08);
    chk("entry9", rr, 16'h00FF);
    // Indirect count-down through the index, which still holds FF from the first test.
    pointer_init_op(8'h3E, 16'h0015);
    run(chan_pkg::OP_DEC_N, 8'h00);
    chk("flags", {fc, fsb, fz}, 3'b000);
    // Extended count-down only with extended addressing configured.
    run(chan_pkg::OP_DEC_X, 8'h08);
    chk("illegal", {ill, done}, 2'b10);
    set_in(8'h10, pc, nctl);
    run(chan_pkg::OP_DEC_X, 8'h08);
    chk("legal", {ill, done}, 2'b01);
    $display("test table_countdown finished");
    // Give-back outside extended mode does nothing but complete.
    set_in(8'h00, pc, nctl);
    run(chan_pkg::OP_GIVE, 8'h00);
    chk("give_nop", {done, pstb, irq}, 3'b100);
    pointer_init_op(8'h10, 16'h5A5A);
    pointer_init_op(8'h30, 16'hC3C3);
    set_in(8'h01, pc, 16'h8000);
    run(chan_pkg::OP_GIVE, 8'h00);
    chk("give", {pstb, pcomp, irq, fz}, 4'hF);
    chk("range", prange, resid);
    // Entry 63 was counted down from 15 to 14 through the index.
    chk("ctl_hi", pctl, 16'h0014);
    // Extended next-block: status copied, no completion and no interrupt.
    run(chan_pkg::OP_GNB, 8'h00);
    chk("status", pstat, 16'h5A5A);
    chk("range", prange, irange);
    chk("no_post", {pcomp, irq, fstb}, 3'b001);
    chk("vlb", {fv, flb, flc}, 3'b100);
    run(chan_pkg::OP_GIVE, 8'h00);
    chk("give_z", fz, 1'b0);
    // Compatibility next-block on the transmit side posts and interrupts.
    set_in(8'h00, pc, 16'h4000);
    run(chan_pkg::OP_GNB, 8'h20);
    chk("status", pstat, 16'hC3C3);
    chk("post", {pstb, pcomp, irq}, 3'b111);
    chk("vlb", {fv, flb, flc}, 3'b010);
    $display("test block_return finished");
    stop_test;
  end
endmodule // channel_ctrl_instr_subset_tb
